// ===== logic/lair_pkg.sv
// Constants and types of the light autorange and interrupt reporting block.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
`default_nettype none

package lair_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_MHZ            = 100;
	localparam int unsigned ASSESS_TIME_MS     = 10;
	localparam int unsigned SHORT_TIME_MS      = 100;
	localparam int unsigned LONG_TIME_MS       = 800;
	localparam int unsigned ASSESS_CYCLES      = ASSESS_TIME_MS * CLK_MHZ * 1000;
	localparam int unsigned SHORT_CYCLES       = SHORT_TIME_MS * CLK_MHZ * 1000;
	localparam int unsigned LONG_CYCLES        = LONG_TIME_MS * CLK_MHZ * 1000;

	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [3:0] ADDR_RESULT         = 4'h0;
	localparam logic [3:0] ADDR_CONFIG         = 4'h4;
	localparam logic [3:0] ADDR_LOW_LIMIT      = 4'h8;
	localparam logic [3:0] ADDR_HIGH_LIMIT     = 4'hC;

	// ------------------------------------------------------------------
	// Configuration register fields
	// ------------------------------------------------------------------
	localparam int CFG_RANGE_LSB               = 12;
	localparam int CFG_PERIOD_BIT              = 11;
	localparam int CFG_OPSTATE_LSB             = 9;
	localparam int CFG_READY_BIT               = 7;
	localparam int CFG_FLAG_HIGH_BIT           = 6;
	localparam int CFG_FLAG_LOW_BIT            = 5;
	localparam int CFG_WINDOW_BIT              = 4;
	localparam int CFG_SENSE_BIT               = 3;
	localparam int CFG_FAULT_LSB               = 0;
	localparam int LOW_TOP_LSB                 = 14;

	// ------------------------------------------------------------------
	// Field codes and reset values
	// ------------------------------------------------------------------
	localparam logic [3:0]  RANGE_AUTO         = 4'hC;
	localparam logic [3:0]  RANGE_MAX          = 4'hB;
	localparam logic [3:0]  RANGE_MIN          = 4'h0;
	localparam logic [1:0]  OPSTATE_SHUTDOWN   = 2'h0;
	localparam logic [1:0]  OPSTATE_SINGLE     = 2'h1;
	localparam logic [1:0]  EOC_TOP_BITS       = 2'h3;
	localparam logic [3:0]  RESET_RANGE        = 4'hC;
	localparam logic [1:0]  RESET_OPSTATE      = 2'h0;
	localparam logic        RESET_WINDOW       = 1'h1;
	localparam logic [15:0] RESET_LOW_LIMIT    = 16'h0000;
	localparam logic [15:0] RESET_HIGH_LIMIT   = 16'hBFFF;

	// ------------------------------------------------------------------
	// Autorange thresholds on the 12-bit fraction of full scale
	// ------------------------------------------------------------------
	localparam logic [11:0] RAISE_LEVEL        = 12'hE00;
	localparam logic [11:0] LOWER1_LEVEL       = 12'h300;
	localparam logic [11:0] LOWER2_LEVEL       = 12'h100;
	localparam logic [11:0] OVERFLOW_VALUE     = 12'hFFF;

	// ------------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY           = 2'h0;
	localparam logic [1:0] RESP_SLVERR         = 2'h2;

	typedef enum logic [2:0] {
		LAIR_IDLE    = 3'b001,
		LAIR_ASSESS  = 3'b010,
		LAIR_CONVERT = 3'b100
	} lair_meas_type;

endpackage

`default_nettype wire

// ===== logic/lair_top.sv
// Light sensor control: autorange sequencing, threshold comparison and
// interrupt reporting, with an AXI4-Lite register slave.
// Assumes a front end that presents a level value and an overflow level
// asynchronous to aclk, and an alert-response strobe on aclk.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Range code 1100b selects automatic full-scale range mode.
// - Auto mode starts with a 10 ms assessment, then picks the range; selected mid-conversion, it adjusts from the current range instead.
// - Result near low side lowers range by one or two settings.
// - Result near upper side raises range by exactly one setting.
// - Overflow in auto mode aborts measurement unreported, reassesses 10 ms, then remeasures.
// - Abort and reassessment may lengthen a measurement past its period.
// - Configuration bit 4 set selects latched window, clear selects hysteresis.
// - Low limit top bits 11b enable end-of-conversion reporting in both modes.
// - Window mode counts faults above high or below low limit.
// - Window fault latches its flag until configuration read, its interrupt until read or alert response.
// - Window mode alert response clears interrupt, keeps flags and ready.
// - Every conversion sets ready; unmet criterion keeps flags, and keeps interrupt unless in EOC mode.
// - Non-shutdown write clears ready, and interrupt in hysteresis EOC mode; leaving window mode clears interrupt.
// - Hysteresis high fault run: interrupt active, flag high set, low cleared.
// - Hysteresis low fault run: interrupt inactive, flag low set, high cleared.
// - Hysteresis mode: register accesses never alter flags; in EOC mode config reads and non-shutdown writes clear interrupt.
// - Hysteresis mode ignores and never answers the alert response.
// - A configuration read clears ready right after it, unless a conversion completes in the same cycle.
// - Pin pulled low when active with sense 0 or inactive with sense 1.
// - End-of-conversion mode activates interrupt on every completion.
// - Fault count sets consecutive same-kind results needed for a change.
module lair_top
	import lair_pkg::*;
#(
	parameter int unsigned ASSESS_COUNT = ASSESS_CYCLES,
	parameter int unsigned SHORT_COUNT  = SHORT_CYCLES,
	parameter int unsigned LONG_COUNT   = LONG_CYCLES
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Front end
	input  wire logic [11:0] fe_value,
	input  wire logic        fe_overflow,
	output logic [3:0]       fe_range,
	output logic             fe_run,
	output logic             fe_assess,
	// Alert response from the serial engine
	input  wire logic        alert_request,
	output logic             alert_answer,
	// Open-drain interrupt pin
	output logic             irq_pin_out,
	output logic             irq_pin_oe_n
);

	typedef struct packed {
		logic          awready;
		logic          aw_have;
		logic [3:0]    aw_addr;
		logic          wready;
		logic          w_have;
		logic [15:0]   w_data;
		logic [1:0]    w_strb;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          arready;
		logic          rvalid;
		logic [31:0]   rdata;
		logic [1:0]    rresp;
		logic [3:0]    range_code;
		logic          integration_period;
		logic [1:0]    op_state;
		logic          window_or_hysteresis;
		logic          irq_output_sense;
		logic [1:0]    fault_count;
		logic [15:0]   low_limit;
		logic [15:0]   high_limit;
		logic [15:0]   result;
		logic          conv_ready;
		logic          flag_high;
		logic          flag_low;
		logic          irq_active;
		logic [3:0]    fault_run;
		logic          fault_run_high;
		lair_meas_type meas;
		logic          run;
		logic [31:0]   timer;
		logic [3:0]    range;
		logic          need_assess;
		logic [11:0]   value_meta;
		logic [11:0]   value_sync;
		logic          ovf_meta;
		logic          ovf_sync;
		logic          alert_answer;
		logic          pin_out;
		logic          pin_oe_n;
	} lair_state_type;

	lair_state_type r;
	lair_state_type next_r;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Consecutive faults needed for each fault count code.
	function automatic logic [3:0] fault_need(input logic [1:0] code);
		unique case (code)
			2'h0: fault_need = 4'h1;
			2'h1: fault_need = 4'h2;
			2'h2: fault_need = 4'h4;
			2'h3: fault_need = 4'h8;
		endcase
	endfunction

	// Range picked from an assessment taken at the top range.
	function automatic logic [3:0] assess_pick(input logic [11:0] v);
		logic [3:0] pick;
		pick = RANGE_MIN;
		for (int i = 0; i < 11; i++) begin
			if (v[i]) begin
				pick = 4'(i + 1);
			end
		end
		if (v[11]) begin
			pick = RANGE_MAX;
		end
		assess_pick = pick;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [15:0] data, input logic [1:0] strb);
		merge16 = {strb[1] ? data[15:8] : old[15:8],
			strb[0] ? data[7:0] : old[7:0]};
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [15:0] cfg_word;
		logic [15:0] wr_cfg;
		logic        cfg_read;
		logic        done;
		logic        hit_high;
		logic        hit_low;
		logic        met;
		logic        latched;
		logic        eoc;
		logic        auto;
		logic [3:0]  fixed_range;
		logic [31:0] period;
		logic [4:0]  adj;
		next_r = r;
		cfg_word = {r.range_code, r.integration_period, r.op_state, 1'b0,
			r.conv_ready, r.flag_high, r.flag_low, r.window_or_hysteresis,
			r.irq_output_sense, 1'b0, r.fault_count};
		wr_cfg = 16'h0000;
		cfg_read = 1'b0;
		done = 1'b0;
		hit_high = 1'b0;
		hit_low = 1'b0;
		met = 1'b0;
		latched = r.window_or_hysteresis;
		eoc = (r.low_limit[LOW_TOP_LSB +: 2] == EOC_TOP_BITS);
		auto = (r.range_code == RANGE_AUTO);
		fixed_range = (r.range_code > RANGE_MAX) ? RANGE_MAX : r.range_code;
		period = r.integration_period ? LONG_COUNT : SHORT_COUNT;
		adj = 5'h00;
		next_r.alert_answer = 1'b0;

		// Front-end levels pass two flip-flops.
		next_r.value_meta = fe_value;
		next_r.value_sync = r.value_meta;
		next_r.ovf_meta = fe_overflow;
		next_r.ovf_sync = r.ovf_meta;

		// --------------------------------------------------------------
		// Write channel
		// --------------------------------------------------------------
		if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end
		if (s_axi_awvalid && r.awready) begin
			next_r.aw_have = 1'b1;
			next_r.aw_addr = s_axi_awaddr[3:0];
		end
		if (s_axi_wvalid && r.wready) begin
			next_r.w_have = 1'b1;
			next_r.w_data = s_axi_wdata[15:0];
			next_r.w_strb = s_axi_wstrb[1:0];
		end
		if (next_r.aw_have && next_r.w_have && !next_r.bvalid) begin
			next_r.aw_have = 1'b0;
			next_r.w_have = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = RESP_OKAY;
			unique case (next_r.aw_addr)
				ADDR_RESULT: begin
				end
				ADDR_CONFIG: begin
					wr_cfg = merge16(cfg_word, next_r.w_data, next_r.w_strb);
					next_r.range_code = wr_cfg[CFG_RANGE_LSB +: 4];
					next_r.integration_period = wr_cfg[CFG_PERIOD_BIT];
					next_r.op_state = wr_cfg[CFG_OPSTATE_LSB +: 2];
					next_r.window_or_hysteresis = wr_cfg[CFG_WINDOW_BIT];
					next_r.irq_output_sense = wr_cfg[CFG_SENSE_BIT];
					next_r.fault_count = wr_cfg[CFG_FAULT_LSB +: 2];
					if (wr_cfg[CFG_RANGE_LSB +: 4] == RANGE_AUTO
							&& (!auto || r.op_state == OPSTATE_SHUTDOWN)) begin
						next_r.need_assess = 1'b1;
					end
					if (wr_cfg[CFG_OPSTATE_LSB +: 2] != OPSTATE_SHUTDOWN) begin
						next_r.conv_ready = 1'b0;
						if (eoc && !latched) begin
							next_r.irq_active = 1'b0;
						end
					end
					if (latched && !wr_cfg[CFG_WINDOW_BIT]) begin
						next_r.irq_active = 1'b0;
					end
				end
				ADDR_LOW_LIMIT: begin
					next_r.low_limit = merge16(r.low_limit, next_r.w_data,
						next_r.w_strb);
				end
				ADDR_HIGH_LIMIT: begin
					next_r.high_limit = merge16(r.high_limit, next_r.w_data,
						next_r.w_strb);
				end
				default: begin
					next_r.bresp = RESP_SLVERR;
				end
			endcase
		end
		next_r.awready = !next_r.aw_have && !next_r.bvalid;
		next_r.wready = !next_r.w_have && !next_r.bvalid;

		// --------------------------------------------------------------
		// Read channel
		// --------------------------------------------------------------
		if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r.arready) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = RESP_OKAY;
			next_r.rdata = 32'h0000_0000;
			unique case (s_axi_araddr[3:0])
				ADDR_RESULT: next_r.rdata[15:0] = r.result;
				ADDR_CONFIG: begin
					next_r.rdata[15:0] = cfg_word;
					cfg_read = 1'b1;
				end
				ADDR_LOW_LIMIT: next_r.rdata[15:0] = r.low_limit;
				ADDR_HIGH_LIMIT: next_r.rdata[15:0] = r.high_limit;
				default: next_r.rresp = RESP_SLVERR;
			endcase
		end
		next_r.arready = !next_r.rvalid;

		if (cfg_read) begin
			next_r.conv_ready = 1'b0;
			if (latched) begin
				next_r.flag_high = 1'b0;
				next_r.flag_low = 1'b0;
				next_r.irq_active = 1'b0;
			end else if (eoc) begin
				next_r.irq_active = 1'b0;
			end
		end

		// Alert answered only in latched mode.
		if (alert_request && latched) begin
			next_r.irq_active = 1'b0;
			next_r.alert_answer = 1'b1;
		end

		// --------------------------------------------------------------
		// Measurement sequencing
		// --------------------------------------------------------------
		next_r.timer = r.timer + 32'h1;
		unique case (r.meas)
			LAIR_IDLE: begin
				next_r.timer = 32'h0;
				if (r.op_state != OPSTATE_SHUTDOWN) begin
					if (auto && r.need_assess) begin
						next_r.meas = LAIR_ASSESS;
						next_r.range = RANGE_MAX;
					end else begin
						next_r.meas = LAIR_CONVERT;
						next_r.range = auto ? r.range : fixed_range;
					end
				end
			end
			LAIR_ASSESS: begin
				if (r.op_state == OPSTATE_SHUTDOWN) begin
					next_r.meas = LAIR_IDLE;
				end else if (r.timer + 32'h1 >= ASSESS_COUNT) begin
					next_r.meas = LAIR_CONVERT;
					next_r.timer = 32'h0;
					next_r.need_assess = 1'b0;
					next_r.range = r.ovf_sync ? RANGE_MAX
						: assess_pick(r.value_sync);
				end
			end
			LAIR_CONVERT: begin
				if (r.op_state == OPSTATE_SHUTDOWN) begin
					next_r.meas = LAIR_IDLE;
				end else if (auto && r.ovf_sync) begin
					// Abort unreported; completion slips past the period.
					next_r.meas = LAIR_ASSESS;
					next_r.range = RANGE_MAX;
					next_r.timer = 32'h0;
				end else if (r.timer + 32'h1 >= period) begin
					done = 1'b1;
					next_r.timer = 32'h0;
					next_r.result = {r.range, r.ovf_sync ? OVERFLOW_VALUE
						: r.value_sync};
					if (auto) begin
						adj = {1'b0, r.range};
						if (r.value_sync >= RAISE_LEVEL) begin
							if (r.range < RANGE_MAX) begin
								adj = adj + 5'h01;
							end
						end else if (r.value_sync < LOWER2_LEVEL) begin
							adj = (r.range > 4'h1) ? adj - 5'h02
								: 5'h00;
						end else if (r.value_sync < LOWER1_LEVEL) begin
							adj = (r.range > RANGE_MIN) ? adj - 5'h01
								: 5'h00;
						end
						next_r.range = adj[3:0];
					end else begin
						next_r.range = fixed_range;
					end
					if (r.op_state == OPSTATE_SINGLE) begin
						next_r.op_state = OPSTATE_SHUTDOWN;
						next_r.meas = LAIR_IDLE;
					end
				end
			end
			default: begin
				next_r.meas = LAIR_IDLE;
			end
		endcase
		next_r.run = (next_r.meas != LAIR_IDLE);

		// --------------------------------------------------------------
		// Comparison and reporting; a completion wins over any clear.
		// --------------------------------------------------------------
		if (done) begin
			hit_high = next_r.result > r.high_limit;
			hit_low = next_r.result < r.low_limit;
			if (!hit_high && !hit_low) begin
				next_r.fault_run = 4'h0;
			end else if (r.fault_run != 4'h0
					&& r.fault_run_high == hit_high) begin
				if (r.fault_run < fault_need(r.fault_count)) begin
					next_r.fault_run = r.fault_run + 4'h1;
				end
			end else begin
				next_r.fault_run = 4'h1;
				next_r.fault_run_high = hit_high;
			end
			met = (hit_high || hit_low)
				&& next_r.fault_run >= fault_need(r.fault_count);
			next_r.conv_ready = 1'b1;
			if (met && latched) begin
				next_r.flag_high = r.flag_high | hit_high;
				next_r.flag_low = r.flag_low | hit_low;
				next_r.irq_active = 1'b1;
			end else if (met) begin
				next_r.flag_high = hit_high;
				next_r.flag_low = hit_low;
				next_r.irq_active = hit_high;
			end
			if (eoc) begin
				next_r.irq_active = 1'b1;
			end
		end

		// Open-drain pin: pulled low per activity and sense.
		next_r.pin_out = 1'b0;
		next_r.pin_oe_n = !(next_r.irq_active ^ next_r.irq_output_sense);
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
			r.range_code <= RESET_RANGE;
			r.op_state <= RESET_OPSTATE;
			r.window_or_hysteresis <= RESET_WINDOW;
			r.low_limit <= RESET_LOW_LIMIT;
			r.high_limit <= RESET_HIGH_LIMIT;
			r.meas <= LAIR_IDLE;
			r.range <= RANGE_MAX;
			r.need_assess <= 1'b1;
			r.pin_oe_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign fe_range = r.range;
	assign fe_run = r.run;
	assign fe_assess = r.meas[1];
	assign alert_answer = r.alert_answer;
	assign irq_pin_out = r.pin_out;
	assign irq_pin_oe_n = r.pin_oe_n;

endmodule

`default_nettype wire

// ===== sim/lair_front_model.sv
// Front-end model: one light level seen through the selected range.
// Assumes the bench sets light and the design the range.
`timescale 1ns/1ps
`default_nettype none
module lair_front_model (
	// Light and range
	input  wire logic [23:0] light,
	input  wire logic [3:0]  range,
	// Reading
	output logic      [11:0] value,
	output logic             overflow
);
	logic [23:0] scaled;

	// Each range step doubles the full scale.
	assign scaled   = light >> range;
	assign overflow = scaled > 24'h000FFF;
	assign value    = overflow ? 12'hFFF : scaled[11:0];
endmodule
`default_nettype wire

// ===== sim/lair_properties.sv
// Checker for lair_top: bus, range sequencing and alert answers.
// Assumes binding into lair_top with its assessment length.
`timescale 1ns/1ps
`default_nettype none
module lair_properties
	import lair_pkg::*;
#(
	parameter int unsigned ASSESS_COUNT = ASSESS_CYCLES
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Front end, alert and pin
	input wire logic [3:0]  fe_range,
	input wire logic        fe_run,
	input wire logic        fe_assess,
	input wire logic        alert_request,
	input wire logic        alert_answer,
	input wire logic        irq_pin_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Cycles of the running assessment.
	int unsigned assess_len;
	always_ff @(posedge aclk)
		assess_len <= (!aresetn || !fe_assess) ? 0 : assess_len + 1;

	property p_range_clamp;
		fe_run |-> fe_range <= RANGE_MAX;
	endproperty
	a_range_clamp: assert property (p_range_clamp)
		else $error("range out of bounds");
	property p_assess_top;
		fe_assess && $past(fe_assess) |-> fe_range == RANGE_MAX;
	endproperty
	a_assess_top: assert property (p_assess_top)
		else $error("assess not at top");
	property p_assess_len;
		$fell(fe_assess) |-> assess_len == ASSESS_COUNT;
	endproperty
	a_assess_len: assert property (p_assess_len)
		else $error("assess length");
	property p_assess_run;
		fe_assess |-> fe_run;
	endproperty
	a_assess_run: assert property (p_assess_run)
		else $error("assess without run");
	property p_alert;
		alert_answer |-> $past(alert_request);
	endproperty
	a_alert: assert property (p_alert)
		else $error("unasked alert answer");
	property p_pin_data;
		irq_pin_out == 1'b0;
	endproperty
	a_pin_data: assert property (p_pin_data)
		else $error("pin data not low");
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read answer late");
	property p_read_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("read data dropped");
	property p_write_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_write_hold: assert property (p_write_hold)
		else $error("write answer dropped");
	property p_write_refuse;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_write_refuse: assert property (p_write_refuse)
		else $error("address taken in answer");
endmodule
`default_nettype wire

// ===== sim/lair_top_test.sv
// Bench for lair_top: register host, front-end model and alert strobe.
// Assumes short timing so a conversion lasts tens of cycles.
`timescale 1ns/1ps
`default_nettype none
module lair_top_test
	import lair_pkg::*;
();
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, alert_request = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
	logic        awready, wready, bvalid, arready, rvalid, alert_answer;
	logic        fe_ovf, fe_run, fe_assess, pin_out, pin_oe_n;
	logic [1:0]  bresp, rresp, s;
	logic [11:0] fe_value;
	logic [3:0]  fe_range, wstrb = 4'hF;
	logic [23:0] light = 0;
	int          errors = 0, n_tests = 0, n_assess = 0;
	// The interrupt line has a pull-up.
	wire logic   irq_line = pin_oe_n ? 1'b1 : pin_out;

	always #5 aclk = ~aclk;
	always @(posedge fe_assess) n_assess++;

	lair_top #(.ASSESS_COUNT(20), .SHORT_COUNT(60), .LONG_COUNT(120)) dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.fe_value(fe_value), .fe_overflow(fe_ovf), .fe_range(fe_range),
		.fe_run(fe_run), .fe_assess(fe_assess),
		.alert_request(alert_request), .alert_answer(alert_answer),
		.irq_pin_out(pin_out), .irq_pin_oe_n(pin_oe_n)
	);
	lair_front_model front_u (
		.light(light), .range(fe_range), .value(fe_value), .overflow(fe_ovf)
	);

	// ----------------------------------------------------------------
	// Tasks and expectations
	// ----------------------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= 32'(a);
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		fork
			begin do @(posedge aclk); while (!awready); awvalid <= 0; end
			begin do @(posedge aclk); while (!wready); wvalid <= 0; end
		join
		bready <= 1;
		do @(posedge aclk); while (!bvalid);
		bready <= 0;
		chk(bresp === RESP_OKAY, "bresp");
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= 32'(a);
		arvalid <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		rready <= 1;
		do @(posedge aclk); while (!rvalid);
		rready <= 0;
		d = rdata;
		s = rresp;
	endtask
	task automatic wait_pin(input logic v);
		for (int i = 0; i < 2000 && irq_line !== v; i++) @(posedge aclk);
	endtask
	task automatic alert(output logic ans);
		alert_request <= 1;
		@(posedge aclk);
		alert_request <= 0;
		@(posedge aclk);
		ans = alert_answer;
	endtask
	function automatic logic [31:0] cfg(input logic w, input logic p,
			input logic [1:0] op);
		return {16'h0, RANGE_AUTO, 1'b0, op, 4'h0, w, p, 3'h0};
	endfunction
	function automatic logic [3:0] exp_pick(input logic [23:0] l);
		logic [12:0] v;
		v = 13'(l >> 11);
		if (v > 13'h07FF) return RANGE_MAX;
		for (int k = 10; k >= 0; k--)
			if (v[k]) return 4'(k + 1);
		return RANGE_MIN;
	endfunction
	// Polls results until one arrives at range r.
	task automatic settle(input logic [3:0] r, input string m);
		for (int i = 0; i < 400; i++) begin
			rd(ADDR_CONFIG);
			if (d[CFG_READY_BIT] === 1'b1) begin
				rd(ADDR_RESULT);
				chk(d[11:0] !== 12'hFFF, m);
				if (d[15:12] === r) break;
			end
		end
		chk(d[15:0] === {r, 12'(light >> r)}, m);
	endtask
	task automatic report_and_stop();
		$display("errors %0d, checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [3:0]  r1;
		logic [23:0] lt;
		logic        ans;
		int          k;
		void'($urandom(87113));
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		rd(ADDR_CONFIG);
		chk(d[15:0] === cfg(RESET_WINDOW, 0, RESET_OPSTATE), "cfg reset");
		rd(ADDR_HIGH_LIMIT);
		chk(d[15:0] === RESET_HIGH_LIMIT, "high reset");
		rd(4'h1);
		chk(s === RESP_SLVERR && d === 32'h0, "unmapped");
		chk(irq_line === 1'b1, "pin at reset");
		r1 = 4'($urandom_range(9, 2));
		lt = 24'($urandom_range(32'h7FF, 32'h400)) << r1;
		light <= lt;
		wr(ADDR_CONFIG, cfg(1, 0, 2));
		settle(exp_pick(lt), "first range");
		light <= 24'hF00 << r1;
		settle(r1 + 4'h1, "raise");
		light <= 24'hE0 << (r1 + 4'h1);
		settle(r1 - 4'h1, "lower");
		k = n_assess;
		light <= 24'hF00 << 11;
		settle(RANGE_MAX, "abort");
		chk(n_assess > k, "reassess");
		wr(ADDR_HIGH_LIMIT, 32'h1000);
		wait_pin(0);
		chk(irq_line === 1'b0, "window fault");
		rd(ADDR_CONFIG);
		chk(d[7:5] === 3'b110, "window flags");
		chk(irq_line === 1'b1, "read clear");
		rd(ADDR_CONFIG);
		chk(d[7:5] === 3'b000, "second read");
		wait_pin(0);
		alert(ans);
		chk(ans === 1'b1 && irq_line === 1'b1, "alert");
		rd(ADDR_CONFIG);
		chk(d[6] === 1'b1, "alert flag");
		wr(ADDR_CONFIG, cfg(0, 0, 2));
		wait_pin(0);
		rd(ADDR_CONFIG);
		chk(d[6:5] === 2'b10 && irq_line === 1'b0, "high");
		alert(ans);
		chk(ans === 1'b0 && irq_line === 1'b0, "hyst alert");
		wstrb <= 4'h2;
		wr(ADDR_HIGH_LIMIT, 32'hFF55);
		wstrb <= 4'hF;
		rd(ADDR_HIGH_LIMIT);
		chk(d === 32'hFF00, "strobe");
		wr(ADDR_LOW_LIMIT, 32'hBFFF);
		wait_pin(1);
		rd(ADDR_CONFIG);
		chk(d[6:5] === 2'b01 && irq_line === 1'b1, "low");
		wr(ADDR_CONFIG, cfg(0, 1, 2));
		wait_pin(0);
		chk(irq_line === 1'b0, "sense");
		wr(ADDR_LOW_LIMIT, 32'hC000);
		wr(ADDR_CONFIG, cfg(1, 0, 2));
		rd(ADDR_CONFIG);
		chk(irq_line === 1'b1, "eoc read");
		wait_pin(0);
		chk(irq_line === 1'b0, "eoc done");
		wr(ADDR_LOW_LIMIT, 32'h0);
		wr(ADDR_CONFIG, cfg(0, 0, 2));
		@(posedge aclk);
		chk(irq_line === 1'b1, "leave eoc");
		report_and_stop();
	end

	initial begin
		#900000;
		errors++;
		report_and_stop();
	end
endmodule

bind lair_top lair_properties #(.ASSESS_COUNT(ASSESS_COUNT)) chk_u (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.fe_range(fe_range), .fe_run(fe_run), .fe_assess(fe_assess),
	.alert_request(alert_request), .alert_answer(alert_answer),
	.irq_pin_out(irq_pin_out)
);
`default_nettype wire
